// ==== clock_reset_regs.vh ====
// register offsets, field positions, reset values and timing counts of the clock and reset unit
`ifndef CLOCK_RESET_REGS_VH
`define CLOCK_RESET_REGS_VH
`define OFS_CONTROL 24'hff_fc40
`define OFS_FAST_PRESC 24'hff_fc42
`define OFS_SLOW_PRESC 24'hff_fc44
`define OFS_AUX_PRESC 24'hff_fc46
`define CTL_SLOW_SEL 0
`define CTL_FAST_SEL 1
`define CTL_PLL_PWD 2
`define CTL_AUX1_EN 3
`define CTL_AUX2_EN 4
`define CTL_POR 5
`define RST_CONTROL 8'h26
`define RST_FAST_PRESC 8'h4f
`define RST_SLOW_PRESC 8'hb6
`define RST_AUX_PRESC 8'hff
`define MODE_X3 3'h3
`define MODE_X4 3'h4
`define MODE_X5 3'h5
`define SLOW_TIMER_LOAD 6'h3f
`define POR_TIMER_LOAD 14'h3fff
`define PLL_LOCK_CYCLES 16'h0040
`endif

// ==== clock_and_reset_unit.v ====
// clock and reset unit: slow clock, pll handshake, dividers, aux clocks, resets, avalon registers
//
// Register access over Avalon-MM is this design's own decision.
`include "clock_reset_regs.vh"
`default_nettype none
module clock_and_reset_unit #(
    parameter [15:0] PLL_LOCK = `PLL_LOCK_CYCLES
) (
    input wire CLK,
    input wire RSTN,
    input wire POWER_UP,
    input wire EXT_RESET_N,
    input wire MAIN_STABLE,
    input wire STOP_SLOW_OSC,
    input wire STOP_PLL,
    input wire OSC32_IN,
    input wire [23:0] ADDRESS,
    input wire READ,
    input wire WRITE,
    input wire [31:0] WRITEDATA,
    input wire [3:0] BYTEENABLE,
    output reg [31:0] READDATA,
    output reg WAITREQUEST,
    output reg [1:0] RESPONSE,
    output reg OSC32_ENABLE,
    output reg SLOW_STABLE,
    output reg SLOW_CLK,
    output reg MAIN_PRESC_ON,
    output reg PLL_ENABLE,
    output reg [2:0] PLL_MODE,
    output reg SYS_FROM_PLL,
    output reg SYS_TICK,
    output reg AUX1_CLK,
    output reg AUX2_CLK,
    output reg SYS_RESET_N,
    output reg POR_FLAG
);

////////////////////////////////////////////////////////////////////////////////
// register bus: one wait cycle, then answer
// one word access per byte register, low lane only
// take: read or write high with no answer pending
// answer: waitrequest low on the following edge
// the write lands on the answer edge, not the take edge
// read data is registered at the take and stands one cycle
// a master still holding its strobe after the answer starts a new take
// on the edge after that, since the pending answer blocks the answer edge
// upper lanes of writedata are ignored; byteenable bit 0 gates writes
// unmapped offsets answer with a slave error and zero data
// full 24-bit address decode, so no register has an alias
reg [7:0] control_ff;
reg [7:0] fast_presc_ff;
reg [7:0] slow_presc_ff;
reg [7:0] aux_presc_ff;
reg ack_ff;
reg pll_stable_ff;
reg [15:0] lock_cnt_ff;
reg osc_toggling_ff;
wire req = (READ | WRITE) & ~ack_ff;
wire wr = WRITE & ack_ff & BYTEENABLE[0];
wire hit_ctl = ADDRESS == `OFS_CONTROL;
wire hit_fast = ADDRESS == `OFS_FAST_PRESC;
wire hit_slow = ADDRESS == `OFS_SLOW_PRESC;
wire hit_aux = ADDRESS == `OFS_AUX_PRESC;
wire mapped = hit_ctl | hit_fast | hit_slow | hit_aux;
wire [7:0] wd = WRITEDATA[7:0];

// byte-select function reused for read mux
function [7:0] pick;
    input [1:0] sel;
    input [7:0] a, b, c, d;
    begin
        case (sel)
            2'h0: pick = a;
            2'h1: pick = b;
            2'h2: pick = c;
            default: pick = d;
        endcase
    end
endfunction

always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        ack_ff <= 1'b0;
        WAITREQUEST <= 1'b1;
        READDATA <= 32'h0000_0000;
        RESPONSE <= 2'h0;
    end else begin
        ack_ff <= req;
        WAITREQUEST <= ~req;
        // unmapped addresses answer with slave error and zero data
        RESPONSE <= (req & ~mapped) ? 2'h2 : 2'h0;
        if (req & READ)
            READDATA <= {24'h00_0000, mapped ? pick(ADDRESS[2:1],
                {2'h0, control_ff[5:2], control_ff[1] | ~pll_stable_ff, control_ff[0]},
                fast_presc_ff, slow_presc_ff, aux_presc_ff) : 8'h00};
        else
            READDATA <= 32'h0000_0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control register with guarded writes
// the select, power-down and power-on bits each have their own guard, so one write may be half taken
// fast select: setting always works, clearing needs power and lock
// power-down: clearing always works, setting needs main clock selected
// the two guards together keep the system clock off a dead pll
// slow select: only taken while the oscillator is seen toggling
// loss of toggling later also forces the slow select back to zero
// power-on bit: software may clear it, never set it
// power-up detect sets it and wins over a clear in the same cycle
// reserved bits 7:6 are never stored and always read zero
// prescaler registers take the whole byte except fast bit 7
reg [7:0] nxt_control;
always @* begin
    nxt_control = control_ff;
    if (wr & hit_ctl) begin
        nxt_control[`CTL_SLOW_SEL] = wd[0] & osc_toggling_ff;
        // pll select only taken when powered and locked
        if (wd[1])
            nxt_control[`CTL_FAST_SEL] = 1'b1;
        else if (!control_ff[`CTL_PLL_PWD] && pll_stable_ff)
            nxt_control[`CTL_FAST_SEL] = 1'b0;
        if (!wd[2])
            nxt_control[`CTL_PLL_PWD] = 1'b0;
        else if (control_ff[`CTL_FAST_SEL])
            nxt_control[`CTL_PLL_PWD] = 1'b1;
        nxt_control[`CTL_AUX1_EN] = wd[3];
        nxt_control[`CTL_AUX2_EN] = wd[4];
        if (!wd[5])
            nxt_control[`CTL_POR] = 1'b0;
        nxt_control[7:6] = 2'h0;
    end
    // oscillator loss forces back to prescaled main clock
    if (!osc_toggling_ff)
        nxt_control[`CTL_SLOW_SEL] = 1'b0;
    if (POWER_UP)
        nxt_control[`CTL_POR] = 1'b1;
end

always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        control_ff <= `RST_CONTROL;
        fast_presc_ff <= `RST_FAST_PRESC;
        slow_presc_ff <= `RST_SLOW_PRESC;
        aux_presc_ff <= `RST_AUX_PRESC;
    end else begin
        control_ff <= nxt_control;
        // software must not touch this while on the pll; hardware does not stop it
        if (wr & hit_fast)
            fast_presc_ff <= {1'b0, wd[6:0]};
        if (wr & hit_slow)
            slow_presc_ff <= wd;
        if (wr & hit_aux)
            aux_presc_ff <= wd;
    end
end

////////////////////////////////////////////////////////////////////////////////
// slow oscillator start-up timer and activity detector
// the oscillator input is asynchronous to the main clock
// two flops synchronise it; the third only marks edges
// the start-up timer counts synchronised rising edges
// so its run time scales with the crystal, not the main clock
// slow stable goes high one cycle after the timer hits zero
// a stop request drops it at once and reloads the timer
// activity detector: any edge within 1024 main cycles
// a crystal slower than that window would be seen as dead
// the window is fixed; the prescaled main clock is the fallback
reg [5:0] slow_timer_ff;
reg osc_s1_ff, osc_s2_ff, osc_s3_ff;
reg [9:0] osc_idle_ff;
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        slow_timer_ff <= `SLOW_TIMER_LOAD;
        OSC32_ENABLE <= 1'b0;
        SLOW_STABLE <= 1'b0;
        osc_s1_ff <= 1'b0;
        osc_s2_ff <= 1'b0;
        osc_s3_ff <= 1'b0;
        osc_idle_ff <= 10'h000;
        osc_toggling_ff <= 1'b0;
    end else begin
        osc_s1_ff <= OSC32_IN;
        osc_s2_ff <= osc_s1_ff;
        osc_s3_ff <= osc_s2_ff;
        if (STOP_SLOW_OSC) begin
            slow_timer_ff <= `SLOW_TIMER_LOAD;
            OSC32_ENABLE <= 1'b0;
            SLOW_STABLE <= 1'b0;
        end else begin
            OSC32_ENABLE <= 1'b1;
            // timer steps on oscillator rising edges, halts at zero
            if (slow_timer_ff != 6'h00 && osc_s2_ff && !osc_s3_ff)
                slow_timer_ff <= slow_timer_ff - 6'h01;
            SLOW_STABLE <= slow_timer_ff == 6'h00;
        end
        // no edge for 1024 main cycles counts as a dead oscillator
        if (osc_s2_ff != osc_s3_ff) begin
            osc_idle_ff <= 10'h000;
            osc_toggling_ff <= 1'b1;
        end else if (osc_idle_ff != 10'h3ff) begin
            osc_idle_ff <= osc_idle_ff + 10'h001;
        end else begin
            osc_toggling_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// slow clock: divide main by 2*(n+1), or follow the oscillator
// the counter toggles the prescaled level every n+1 main cycles
// so a full slow period is 2*(n+1) main cycles, 2 through 512
// the counter is held at zero while the oscillator is chosen
// which stands in for stopping the prescaler to save power
// a prescaler write applies to the half period in progress; a value at or below the count ends it at the next edge
// no speed check here: software keeps the result under 100 kHz
// the oscillator path uses the synchronised level, two cycles late
// switching sources may stretch or shorten one slow period
reg [7:0] slow_cnt_ff;
reg presc_clk_ff;
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        slow_cnt_ff <= 8'h00;
        presc_clk_ff <= 1'b0;
        SLOW_CLK <= 1'b0;
        MAIN_PRESC_ON <= 1'b1;
    end else begin
        MAIN_PRESC_ON <= ~control_ff[`CTL_SLOW_SEL];
        if (control_ff[`CTL_SLOW_SEL]) begin
            slow_cnt_ff <= 8'h00;
        end else if (slow_cnt_ff >= slow_presc_ff) begin
            slow_cnt_ff <= 8'h00;
            presc_clk_ff <= ~presc_clk_ff;
        end else begin
            slow_cnt_ff <= slow_cnt_ff + 8'h01;
        end
        SLOW_CLK <= control_ff[`CTL_SLOW_SEL] ? osc_s2_ff : presc_clk_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pll power and lock model: lock after a fixed settle count
// the pll runs only with power-down clear and no stop request
// lock comes pll_lock+1 cycles after both conditions hold
// any drop of power clears the lock at once
// the system clock follows the pll only while it is locked
// so a stop request forces a fall back to the main clock
// the mode output is filtered so reserved codes never leave the block
// software must not change the mode while running from the pll
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        lock_cnt_ff <= 16'h0000;
        pll_stable_ff <= 1'b0;
        PLL_ENABLE <= 1'b0;
        PLL_MODE <= `MODE_X4;
        SYS_FROM_PLL <= 1'b0;
    end else begin
        PLL_ENABLE <= ~control_ff[`CTL_PLL_PWD] & ~STOP_PLL;
        // reserved codes fall back to x4 so the pll never sees them
        PLL_MODE <= (fast_presc_ff[6:4] == `MODE_X3 || fast_presc_ff[6:4] == `MODE_X5) ?
            fast_presc_ff[6:4] : `MODE_X4;
        if (control_ff[`CTL_PLL_PWD] || STOP_PLL) begin
            lock_cnt_ff <= 16'h0000;
            pll_stable_ff <= 1'b0;
        end else if (lock_cnt_ff < PLL_LOCK) begin
            lock_cnt_ff <= lock_cnt_ff + 16'h0001;
        end else begin
            pll_stable_ff <= 1'b1;
        end
        SYS_FROM_PLL <= ~control_ff[`CTL_FAST_SEL] & pll_stable_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// system divider and two aux prescalers, one tick per n+1 main cycles
// ticks are one-cycle enables, not divided clocks, to keep one domain
// divisor zero gives a tick on every cycle
// aux counters restart from zero whenever their gate closes
// so the first tick after enabling comes a full period later
// the aux gate needs both the enable bit and a stable main clock
reg [3:0] sys_cnt_ff;
reg [3:0] aux_cnt_ff [0:1];
wire [1:0] aux_en = control_ff[4:3] & {2{MAIN_STABLE}};
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        sys_cnt_ff <= 4'h0;
        SYS_TICK <= 1'b0;
    end else if (sys_cnt_ff >= fast_presc_ff[3:0]) begin
        sys_cnt_ff <= 4'h0;
        SYS_TICK <= 1'b1;
    end else begin
        sys_cnt_ff <= sys_cnt_ff + 4'h1;
        SYS_TICK <= 1'b0;
    end
end

reg [1:0] aux_tick_ff;
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : aux
        always @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                aux_cnt_ff[g] <= 4'h0;
                aux_tick_ff[g] <= 1'b0;
            end else if (!aux_en[g]) begin
                aux_cnt_ff[g] <= 4'h0;
                aux_tick_ff[g] <= 1'b0;
            end else if (aux_cnt_ff[g] >= aux_presc_ff[4*g+3 -: 4]) begin
                aux_cnt_ff[g] <= 4'h0;
                aux_tick_ff[g] <= 1'b1;
            end else begin
                aux_cnt_ff[g] <= aux_cnt_ff[g] + 4'h1;
                aux_tick_ff[g] <= 1'b0;
            end
        end
    end
endgenerate

always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        AUX1_CLK <= 1'b0;
        AUX2_CLK <= 1'b0;
    end else begin
        AUX1_CLK <= aux_tick_ff[0];
        AUX2_CLK <= aux_tick_ff[1];
    end
end

////////////////////////////////////////////////////////////////////////////////
// power-on timer and internal reset
reg [13:0] por_timer_ff;
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        por_timer_ff <= `POR_TIMER_LOAD;
        SYS_RESET_N <= 1'b0;
        POR_FLAG <= 1'b0;
    end else begin
        if (POWER_UP)
            por_timer_ff <= `POR_TIMER_LOAD;
        else if (por_timer_ff != 14'h0000)
            por_timer_ff <= por_timer_ff - 14'h0001;
        SYS_RESET_N <= ~POWER_UP & (por_timer_ff == 14'h0000) & EXT_RESET_N;
        POR_FLAG <= control_ff[`CTL_POR];
    end
end

endmodule
`default_nettype wire

// ==== cru_props.sv ====
// concurrent checks on the ports of the clock and reset unit
`default_nettype none
module cru_props #(
    parameter [15:0] PLL_LOCK = 16'h0040
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic WAITREQUEST,
    input wire logic STOP_SLOW_OSC,
    input wire logic OSC32_ENABLE,
    input wire logic SLOW_STABLE,
    input wire logic PLL_ENABLE,
    input wire logic SYS_FROM_PLL,
    input wire logic MAIN_STABLE,
    input wire logic AUX1_CLK,
    input wire logic AUX2_CLK,
    input wire logic EXT_RESET_N,
    input wire logic SYS_RESET_N
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    // bus answers one cycle after the take, for one cycle only
    a_answer_time: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("late bus answer");
    a_answer_once: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("bus answer held too long");
    // one cycle of slack; the enable flop alone drops it one edge after the request
    a_osc_stop: assert property (STOP_SLOW_OSC [*3] |-> !OSC32_ENABLE)
        else $error("oscillator on during stop");
    a_stable_low: assert property ($fell(STOP_SLOW_OSC) |-> !SLOW_STABLE [*8])
        else $error("slow stable before timer ran");
    a_pll_gate: assert property (SYS_FROM_PLL |-> PLL_ENABLE)
        else $error("running from a pll that is off");
    // tick flop plus output flop: two edges of latency before the pins go quiet
    a_aux_gate: assert property (!MAIN_STABLE [*3] |-> !AUX1_CLK && !AUX2_CLK)
        else $error("aux clock with unstable main");
    // internal reset follows the pin
    a_ext_hold: assert property (!EXT_RESET_N [*3] |-> !SYS_RESET_N)
        else $error("reset released with pin low");
    a_por_release: assert property ($rose(SYS_RESET_N) |-> $past(EXT_RESET_N))
        else $error("reset released while pin was low");
endmodule
bind clock_and_reset_unit cru_props #(.PLL_LOCK(PLL_LOCK)) props_u (.CLK, .RSTN, .READ, .WRITE, .WAITREQUEST,
    .STOP_SLOW_OSC, .OSC32_ENABLE, .SLOW_STABLE, .PLL_ENABLE, .SYS_FROM_PLL, .MAIN_STABLE, .AUX1_CLK, .AUX2_CLK,
    .EXT_RESET_N, .SYS_RESET_N);
`default_nettype wire

// ==== osc32_model.sv ====
// low-frequency crystal model, fitted or absent, gated by the oscillator enable
`default_nettype none
module osc32_model #(
    parameter int HALF = 8
) (
    input wire logic CLK,
    input wire logic run,
    input wire logic en,
    output logic osc
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial osc = 1'b0;
    // a stopped crystal gives no edges, so the level just stands
    always @(posedge CLK) begin
        if (run && en) begin
            n <= (n == HALF - 1) ? 0 : n + 1;
            if (n == HALF - 1)
                osc <= ~osc;
        end
    end
endmodule
`default_nettype wire

// ==== test_clock_and_reset_unit.sv ====
// self-checking bench of the clock and reset unit
`include "clock_reset_regs.vh"
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("FAIL %0t %h %h", $time, a, e); end end
module test_clock_and_reset_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RSTN = 1'b0, POWER_UP = 1'b0, EXT_RESET_N = 1'b1, MAIN_STABLE = 1'b1, STOP_SLOW_OSC = 1'b0;
    logic READ = 1'b0, WRITE = 1'b0, run = 1'b1, osc, WAITREQUEST, OSC32_ENABLE, SLOW_STABLE, SLOW_CLK;
    logic MAIN_PRESC_ON, PLL_ENABLE, SYS_FROM_PLL, SYS_TICK, AUX1_CLK, AUX2_CLK, SYS_RESET_N, POR_FLAG;
    logic [23:0] ADDRESS = 24'h00_0000;
    logic [31:0] WRITEDATA = 32'h0000_0000, READDATA;
    logic [1:0] RESPONSE, r;
    logic [2:0] PLL_MODE;
    logic [7:0] q;
    int fails = 0, num_checks = 0, cyc = 0, c, k;
    localparam logic [23:0] CTL = `OFS_CONTROL, FPR = `OFS_FAST_PRESC;
    clock_and_reset_unit dut_u (.CLK, .RSTN, .POWER_UP, .EXT_RESET_N, .MAIN_STABLE, .STOP_SLOW_OSC,
        .STOP_PLL(1'b0), .OSC32_IN(osc), .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE(4'h1), .READDATA,
        .WAITREQUEST, .RESPONSE, .OSC32_ENABLE, .SLOW_STABLE, .SLOW_CLK, .MAIN_PRESC_ON, .PLL_ENABLE,
        .PLL_MODE, .SYS_FROM_PLL, .SYS_TICK, .AUX1_CLK, .AUX2_CLK, .SYS_RESET_N, .POR_FLAG);
    osc32_model osc_u (.CLK, .run, .en(OSC32_ENABLE), .osc);
    ////////////////////////////////////////////////////////////
    // 10 MHz clock and a cycle ceiling against hangs
    initial begin
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // request held until waitrequest is seen low; only the ceiling ends a hang
    task automatic bus(input logic rd, input logic [23:0] a, input logic [7:0] d);
        @(posedge CLK);
        READ <= rd;
        WRITE <= !rd;
        ADDRESS <= a;
        WRITEDATA <= {24'h00_0000, d};
        do @(posedge CLK); while (WAITREQUEST !== 1'b0);
        q = READDATA[7:0];
        r = RESPONSE;
        READ <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CLK);
        // outputs launched at that edge are settled by the falling edge
        @(negedge CLK);
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rdc(input logic [23:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00);
        `CHK(q, e)
    endtask
    // high samples of one clock output over n cycles
    task automatic cnt(input int s, input int n);
        c = 0;
        repeat (n) begin
            @(posedge CLK);
            c += s == 0 ? SYS_TICK : s == 1 ? AUX1_CLK : s == 2 ? AUX2_CLK : SLOW_CLK;
        end
    endtask
    task automatic por_wait();
        c = 0;
        while (SYS_RESET_N !== 1'b1) begin
            @(posedge CLK);
            c++;
        end
        `CHK(c >= 16370 && c <= 16392, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(CTL, 8'h26);
        rdc(FPR, 8'h4f);
        rdc(`OFS_SLOW_PRESC, 8'hb6);
        rdc(`OFS_AUX_PRESC, 8'hff);
        `CHK(PLL_MODE, 3'h4)
        `CHK(MAIN_PRESC_ON, 1'b1)
        rdc(24'hff_fc48, 8'h00);
        `CHK(r, 2'b10)
    endtask
    task automatic t_sys();
        cnt(0, 48);
        `CHK(c, 3)
        wr(FPR, 8'h40);
        w(20);
        cnt(0, 48);
        `CHK(c, 48)
    endtask
    task automatic t_aux();
        wr(`OFS_AUX_PRESC, 8'h31);
        wr(CTL, 8'h3e);
        w(20);
        cnt(1, 48);
        `CHK(c, 24)
        cnt(2, 48);
        `CHK(c, 12)
        MAIN_STABLE <= 1'b0;
        w(3);
        cnt(1, 48);
        `CHK(c, 0)
        MAIN_STABLE <= 1'b1;
        wr(CTL, 8'h26);
        w(3);
        cnt(2, 48);
        `CHK(c, 0)
    endtask
    // divisor 100 keeps the synthesized slow clock at 100 kHz
    task automatic t_slow();
        wr(`OFS_SLOW_PRESC, 8'h31);
        w(210);
        cnt(3, 200);
        `CHK(c, 100)
    endtask
    task automatic t_osc();
        STOP_SLOW_OSC <= 1'b1;
        w(300);
        `CHK(OSC32_ENABLE, 1'b0)
        `CHK(SLOW_STABLE, 1'b0)
        STOP_SLOW_OSC <= 1'b0;
        c = 0;
        while (SLOW_STABLE !== 1'b1) begin
            @(posedge CLK);
            c++;
        end
        `CHK(c >= 992 && c <= 1040, 1'b1)
    endtask
    task automatic t_sel();
        run <= 1'b0;
        w(1100);
        wr(CTL, 8'h27);
        rdc(CTL, 8'h26);
        `CHK(MAIN_PRESC_ON, 1'b1)
        run <= 1'b1;
        w(40);
        wr(CTL, 8'h27);
        rdc(CTL, 8'h27);
        `CHK(MAIN_PRESC_ON, 1'b0)
        wr(CTL, 8'h26);
    endtask
    task automatic t_pll();
        for (k = 3; k <= 5; k++) begin
            wr(FPR, {1'b0, k[2:0], 4'hf});
            `CHK(PLL_MODE, k[2:0])
        end
        wr(FPR, 8'h7f);
        `CHK(PLL_MODE, 3'h4)
        wr(FPR, 8'h4f);
        wr(CTL, 8'h24);
        rdc(CTL, 8'h26);
        wr(CTL, 8'h22);
        `CHK(PLL_ENABLE, 1'b1)
        k = 0;
        do begin
            wr(CTL, 8'h20);
            bus(1'b1, CTL, 8'h00);
            k++;
        end while (q[1] !== 1'b0);
        `CHK(k > 1, 1'b1)
        `CHK(SYS_FROM_PLL, 1'b1)
        wr(CTL, 8'h24);
        rdc(CTL, 8'h20);
        wr(CTL, 8'h22);
        w(2);
        `CHK(SYS_FROM_PLL, 1'b0)
        wr(CTL, 8'h26);
        rdc(CTL, 8'h26);
        `CHK(PLL_ENABLE, 1'b0)
    endtask
    task automatic t_rst();
        wr(CTL, 8'h06);
        rdc(CTL, 8'h06);
        `CHK(POR_FLAG, 1'b0)
        wr(CTL, 8'h26);
        rdc(CTL, 8'h06);
        EXT_RESET_N <= 1'b0;
        w(30);
        `CHK(SYS_RESET_N, 1'b0)
        EXT_RESET_N <= 1'b1;
        w(5);
        `CHK(SYS_RESET_N, 1'b1)
        POWER_UP <= 1'b1;
        w(1);
        POWER_UP <= 1'b0;
        w(3);
        `CHK(POR_FLAG, 1'b1)
        `CHK(SYS_RESET_N, 1'b0)
        por_wait();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        w(2);
        RSTN <= 1'b1;
        por_wait();
        `CHK(POR_FLAG, 1'b1)
        t_regs();
        t_sys();
        t_aux();
        t_slow();
        t_osc();
        t_sel();
        t_pll();
        t_rst();
        end_sim();
    end
endmodule
`default_nettype wire
